// *** hdl/memmap_pkg.sv ***
/*
 Shared constants for the memory-map decoder: sizes, overlay codes,
 access spaces, register indices, reset values and sequencer states.
 Assumes a single 50 MHz clock domain and 14-bit memory addresses.
*/
`default_nettype none
package memmap_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   // power-up reset hold the board supplies, in input-clock cycles
   localparam int unsigned PWRUP_HOLD_CYCLES = 2000;
   localparam int unsigned PM_WORDS = 16384;
   localparam int unsigned DM_USER_WORDS = 16352;
   localparam logic [13:0] PM_START_ADDR = 14'h0000;
   localparam logic [13:0] DM_CTRL_BASE = 14'h3FE0;
   localparam logic [1:0] OVL_NONE = 2'h0;
   localparam logic [1:0] OVL_ONE = 2'h1;
   localparam logic [1:0] OVL_TWO = 2'h2;
   localparam logic [1:0] SP_PM = 2'h0;
   localparam logic [1:0] SP_DM = 2'h1;
   localparam logic [1:0] SP_IO = 2'h2;
   localparam logic [2:0] WAIT_RST = 3'h7;
   localparam logic [2:0] BYTE_WAIT = 3'h3;
   localparam logic [3:0] STACK_EMPTY = 4'h0;
   localparam logic [3:0] STACK_DEPTH = 4'hC;
   localparam logic [9:0] IRQ_MASK_RST = 10'h000;
   localparam logic [6:0] MODE_STATUS_RST = 7'h00;
   localparam logic [1:0] BOOT_BYTE_LAST = 2'h2;
   localparam logic [4:0] BOOT_WORD_LAST = 5'h1F;
   // register word index; byte address is four times the index
   localparam logic [3:0] IDX_IO_REGION3 = 4'h3;
   localparam logic [3:0] IDX_DATA_WAIT = 4'h4;
   localparam logic [3:0] IDX_PM_OVERLAY = 4'h5;
   localparam logic [3:0] IDX_DM_OVERLAY = 4'h6;
   localparam logic [3:0] IDX_MODE_STATUS = 4'h7;
   localparam logic [3:0] IDX_IRQ_MASK = 4'h8;
   localparam logic [3:0] IDX_STATUS = 4'h9;
   localparam int STAT_BOOT = 4;
   localparam int STAT_RUN = 5;
   localparam int STAT_MAP = 6;
   typedef enum logic [4:0] {
      ST_CHECK = 5'h01,
      ST_BOOT = 5'h02,
      ST_BWAIT = 5'h04,
      ST_IDLE = 5'h08,
      ST_EXT = 5'h10
   } seq_state_e;
endpackage
`default_nettype wire

// *** hdl/addr_decode.sv ***
/*
 Combinational address decoder: on-chip or external, overlay address
 bit 13, control-register window and I/O wait region.
 Assumes the program overlay code is already forced to none in compatibility map.
*/
`timescale 1ns/1ps
`default_nettype none
module addr_decode
   import memmap_pkg::*;
(
   // access
   input wire logic [1:0] space,
   input wire logic [13:0] addr,
   // configuration
   input wire logic map,
   input wire logic [1:0] pm_ovl,
   input wire logic [1:0] dm_ovl,
   // result
   output logic is_ext,
   output logic is_ctrl,
   output logic [1:0] io_region,
   output logic [13:0] ext_addr
);
   // codes other than one and two act as no overlay
   function automatic logic ovl_on(input logic [1:0] v);
      return (v == OVL_ONE) || (v == OVL_TWO); // [RL20]
   endfunction

   function automatic logic [13:0] ovl_addr(input logic [1:0] v,
                                            input logic [13:0] a);
      return {v == OVL_TWO, a[12:0]};
   endfunction

   always_comb begin
      is_ext = 1'b0;
      is_ctrl = 1'b0;
      ext_addr = addr;
      io_region = addr[10:9]; // [RL16]
      case (space)
         SP_PM: begin
            if (map) begin
               is_ext = !addr[13]; // [RL9]
            end else begin
               is_ext = addr[13] && ovl_on(pm_ovl); // [RL6] [RL7]
               ext_addr = ovl_addr(pm_ovl, addr); // [RL8]
            end
         end
         SP_DM: begin
            is_ext = !addr[13] && ovl_on(dm_ovl); // [RL12]
            is_ctrl = !is_ext && (addr >= DM_CTRL_BASE); // [RL11]
            ext_addr = ovl_addr(dm_ovl, addr); // [RL13]
         end
         SP_IO: begin
            is_ext = 1'b1;
            // upper bits held low rather than left floating
            ext_addr = {3'b000, addr[10:0]}; // [RL15]
         end
         default: is_ext = 1'b0;
      endcase
   end
endmodule // addr_decode
`default_nettype wire

// *** hdl/wait_counter.sv ***
/*
 Wait-state down counter for one external access at a time.
 Assumes load is pulsed only while the counter is idle.
*/
`timescale 1ns/1ps
`default_nettype none
module wait_counter (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // control
   input wire logic load,
   input wire logic [2:0] load_val,
   // status
   output logic last
);
   logic [2:0] cnt_q;
   logic busy_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 3'h0;
         busy_q <= 1'b0;
      end else if (ce) begin
         if (load) begin
            cnt_q <= load_val;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (cnt_q == 3'h0) begin
               busy_q <= 1'b0;
            end else begin
               cnt_q <= cnt_q - 3'h1;
            end
         end
      end
   end

   assign last = busy_q && (cnt_q == 3'h0);
endmodule // wait_counter
`default_nettype wire

// *** hdl/memmap_ctrl.sv ***
/*
 Memory-map controller: on-chip program and data RAM, overlay decode,
 external and I/O wait states, boot load from byte memory, reset state
 and an APB register slave.
 Assumes a core that holds each access request until acc_done.
*/
// Our own choices: the register addresses and the APB slave port.
// Functional notes
// RL1: reset empties stacks, masks interrupts, clears mode.
// RL2: boot if no bus request, map low.
// RL3: board holds reset 2000 input clocks.
// RL4: later resets need no clock settling.
// RL5: 24-bit program RAM, fetch plus data.
// RL6: map low, overlay zero: all internal.
// RL7: program overlay set: upper half external.
// RL8: program overlay one/two sets A13 low/high.
// RL9: map high: no boot, lower half external.
// RL10: overlays unsaved, fetch ignores program overlay.
// RL11: 16-bit data, top 32 words registers.
// RL12: data overlay set: lower half external.
// RL13: data overlay one/two sets A13 low/high.
// RL14: internal one cycle, external data waits.
// RL15: I/O uses eleven address bits only.
// RL16: I/O waits from four region settings.
// RL17: only I/O instructions reach I/O space.
// RL18: byte memory 8-bit, 22-bit address.
// RL19: byte data 15:8, address 23:16 plus 13:0.
// RL20: overlay code three decodes as none.
`timescale 1ns/1ps
`default_nettype none
module memmap_ctrl
   import memmap_pkg::*;
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // system pins
   input wire logic memory_map_select_pin,
   input wire logic bus_req,
   // core data access
   input wire logic acc_req,
   input wire logic [1:0] acc_space,
   input wire logic acc_io_instr,
   input wire logic acc_wr,
   input wire logic [13:0] acc_addr,
   input wire logic [23:0] acc_wdata,
   output logic [23:0] acc_rdata,
   output logic acc_done,
   output logic acc_refused,
   // core fetch and control
   input wire logic [13:0] fetch_addr,
   output logic [23:0] fetch_data,
   input wire logic stack_push,
   input wire logic stack_pop,
   output logic [3:0] stack_level,
   output logic core_run,
   output logic [9:0] irq_mask,
   output logic [6:0] mode_status,
   // external bus
   output logic [13:0] ext_addr,
   output logic [23:0] ext_dout,
   output logic [1:0] ext_doe,
   input wire logic [23:0] ext_din,
   output logic pm_sel_n,
   output logic dm_sel_n,
   output logic io_sel_n,
   output logic byte_sel_n,
   output logic rd_n,
   output logic wr_n
);
   logic [23:0] pm_mem [0:PM_WORDS-1]; // [RL5]
   logic [15:0] dm_mem [0:DM_USER_WORDS-1]; // [RL11]
   seq_state_e st_q;
   logic map_q;
   logic [2:0] io_region_wait_q [0:3];
   logic [2:0] data_wait_count_q;
   logic [1:0] program_overlay_select_q;
   logic [1:0] data_overlay_select_q;
   logic [1:0] bsel_q;
   logic [4:0] bword_q;
   logic [6:0] bcnt_q;
   logic [15:0] basm_q;
   logic [1:0] sp_q;
   logic [2:0] ws_q;
   logic [2:0] ext_len_q;
   logic [21:0] baddr;
   logic dec_ext, dec_ctrl, wc_last, wc_load;
   logic [1:0] dec_region;
   logic [13:0] dec_addr;
   logic [2:0] io_ws, ws_sel;
   logic take, refuse, take_int, take_ext;
   logic apb_setup, apb_wr_go, apb_bad;
   logic [3:0] apb_idx;
   logic reg_we;
   logic [3:0] reg_widx;
   logic [15:0] reg_wdata;
   logic [23:0] int_rdata;
   logic boot_busy;

   function automatic logic [15:0] reg_value(input logic [3:0] idx);
      logic [15:0] v;
      v = 16'h0000;
      if (idx <= IDX_IO_REGION3) begin
         v[2:0] = io_region_wait_q[idx[1:0]];
      end else begin
         case (idx)
            IDX_DATA_WAIT: v[2:0] = data_wait_count_q;
            IDX_PM_OVERLAY: v[1:0] = program_overlay_select_q;
            IDX_DM_OVERLAY: v[1:0] = data_overlay_select_q;
            IDX_MODE_STATUS: v[6:0] = mode_status;
            IDX_IRQ_MASK: v[9:0] = irq_mask;
            IDX_STATUS: begin
               v[3:0] = stack_level;
               v[STAT_BOOT] = boot_busy;
               v[STAT_RUN] = core_run;
               v[STAT_MAP] = map_q;
            end
            default: v = 16'h0000;
         endcase
      end
      return v;
   endfunction

   addr_decode u_dec (
      .space(acc_space),
      .addr(acc_addr),
      .map(map_q),
      .pm_ovl(program_overlay_select_q),
      .dm_ovl(data_overlay_select_q),
      .is_ext(dec_ext),
      .is_ctrl(dec_ctrl),
      .io_region(dec_region),
      .ext_addr(dec_addr)
   );

   wait_counter u_wait (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .load(wc_load),
      .load_val(st_q == ST_BOOT ? BYTE_WAIT : ws_sel),
      .last(wc_last)
   );

   assign boot_busy = (st_q == ST_BOOT) || (st_q == ST_BWAIT);
   assign baddr = {15'h0000, bcnt_q}; // [RL18]

   // apb decode; a pending register write holds off core accesses
   assign apb_idx = paddr[5:2];
   assign apb_bad = (paddr[1:0] != 2'h0) || (paddr[7:6] != 2'h0) ||
                    (apb_idx > IDX_STATUS);
   assign apb_setup = ce && psel && !penable;
   assign apb_wr_go = ce && psel && penable && pready && pwrite && !apb_bad;

   assign take = ce && (st_q == ST_IDLE) && acc_req && !acc_done &&
                 !apb_wr_go;
   assign refuse = (acc_space == SP_IO) ? !acc_io_instr // [RL17]
                                        : (acc_space == 2'h3);
   assign take_int = take && !refuse && !dec_ext;
   assign take_ext = take && !refuse && dec_ext;
   assign wc_load = ce && ((st_q == ST_BOOT) || take_ext);
   assign io_ws = io_region_wait_q[dec_region]; // [RL16]
   // no program wait setting exists, so external program runs at zero
   assign ws_sel = (acc_space == SP_DM) ? data_wait_count_q : // [RL14]
                   (acc_space == SP_IO) ? io_ws : 3'h0;

   assign reg_we = apb_wr_go ||
                   (take_int && acc_wr && (acc_space == SP_DM) && dec_ctrl &&
                    !acc_addr[4]); // [RL11]
   assign reg_widx = apb_wr_go ? apb_idx : acc_addr[3:0];
   assign reg_wdata = apb_wr_go ? pwdata[15:0] : acc_wdata[15:0];

   always_comb begin
      int_rdata = 24'h000000;
      if (acc_space == SP_PM) begin
         int_rdata = pm_mem[acc_addr];
      end else if (dec_ctrl) begin
         int_rdata = {8'h00,
                      acc_addr[4] ? 16'h0000 : reg_value(acc_addr[3:0])};
      end else begin
         int_rdata = {8'h00, dm_mem[acc_addr]};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (ce) begin
         if (apb_setup) begin
            pready <= 1'b1;
            pslverr <= apb_bad;
            prdata <= apb_bad ? 32'h00000000 : {16'h0000, reg_value(apb_idx)};
         end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   // wait settings and overlays; interrupts never save or restore them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            io_region_wait_q[i] <= WAIT_RST;
         end
         data_wait_count_q <= WAIT_RST;
         program_overlay_select_q <= OVL_NONE;
         data_overlay_select_q <= OVL_NONE;
      end else if (ce) begin
         if (map_q) begin
            program_overlay_select_q <= OVL_NONE; // [RL9]
         end else if (reg_we && (reg_widx == IDX_PM_OVERLAY)) begin
            program_overlay_select_q <= reg_wdata[1:0]; // [RL10]
         end
         if (reg_we && (reg_widx <= IDX_IO_REGION3)) begin
            io_region_wait_q[reg_widx[1:0]] <= reg_wdata[2:0];
         end
         if (reg_we && (reg_widx == IDX_DATA_WAIT)) begin
            data_wait_count_q <= reg_wdata[2:0];
         end
         if (reg_we && (reg_widx == IDX_DM_OVERLAY)) begin
            data_overlay_select_q <= reg_wdata[1:0]; // [RL10]
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_mask <= IRQ_MASK_RST; // [RL1]
         mode_status <= MODE_STATUS_RST; // [RL1]
      end else if (ce && reg_we) begin
         if (reg_widx == IDX_IRQ_MASK) begin
            irq_mask <= reg_wdata[9:0];
         end
         if (reg_widx == IDX_MODE_STATUS) begin
            mode_status <= reg_wdata[6:0];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stack_level <= STACK_EMPTY; // [RL1]
      end else if (ce) begin
         if (stack_push && !stack_pop && (stack_level < STACK_DEPTH)) begin
            stack_level <= stack_level + 4'h1;
         end else if (stack_pop && !stack_push &&
                      (stack_level != STACK_EMPTY)) begin
            stack_level <= stack_level - 4'h1;
         end
      end
   end

   // sequencer starts straight after any reset: the clock never stops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_CHECK; // [RL4]
         map_q <= 1'b0;
         core_run <= 1'b0;
         bsel_q <= 2'h0;
         bword_q <= 5'h00;
         bcnt_q <= 7'h00;
         basm_q <= 16'h0000;
      end else if (ce) begin
         case (st_q)
            ST_CHECK: begin
               map_q <= memory_map_select_pin;
               if (!bus_req) begin
                  st_q <= memory_map_select_pin ? ST_IDLE : ST_BOOT; // [RL2]
                  core_run <= memory_map_select_pin; // [RL9]
               end
            end
            ST_BOOT: st_q <= ST_BWAIT;
            ST_BWAIT: begin
               if (wc_last) begin
                  basm_q <= {basm_q[7:0], ext_din[15:8]}; // [RL19]
                  bcnt_q <= bcnt_q + 7'h01;
                  st_q <= ST_BOOT;
                  if (bsel_q == BOOT_BYTE_LAST) begin
                     bsel_q <= 2'h0;
                     bword_q <= bword_q + 5'h01;
                     if (bword_q == BOOT_WORD_LAST) begin
                        st_q <= ST_IDLE;
                        core_run <= 1'b1; // [RL2]
                     end
                  end else begin
                     bsel_q <= bsel_q + 2'h1;
                  end
               end
            end
            ST_IDLE: begin
               if (take_ext) begin
                  st_q <= ST_EXT;
               end
            end
            ST_EXT: begin
               if (wc_last) begin
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_CHECK;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_addr <= 14'h0000;
         ext_dout <= 24'h000000;
         ext_doe <= 2'h0;
         pm_sel_n <= 1'b1;
         dm_sel_n <= 1'b1;
         io_sel_n <= 1'b1;
         byte_sel_n <= 1'b1;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         sp_q <= SP_PM;
         ws_q <= 3'h0;
      end else if (ce) begin
         if (st_q == ST_BOOT) begin
            ext_addr <= baddr[13:0]; // [RL19]
            ext_dout <= {baddr[21:14], 16'h0000}; // [RL19]
            ext_doe <= 2'h2;
            byte_sel_n <= 1'b0; // [RL18]
            rd_n <= 1'b0;
         end else if (take_ext) begin
            ext_addr <= dec_addr;
            ext_dout <= (acc_space == SP_PM) ? acc_wdata
                                             : {acc_wdata[15:0], 8'h00};
            ext_doe <= {2{acc_wr}};
            pm_sel_n <= acc_space != SP_PM;
            dm_sel_n <= acc_space != SP_DM;
            io_sel_n <= acc_space != SP_IO; // [RL17]
            rd_n <= acc_wr;
            wr_n <= !acc_wr;
            sp_q <= acc_space;
            ws_q <= ws_sel; // [RL14]
         end else if (wc_last) begin
            ext_doe <= 2'h0;
            pm_sel_n <= 1'b1;
            dm_sel_n <= 1'b1;
            io_sel_n <= 1'b1;
            byte_sel_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_done <= 1'b0;
         acc_refused <= 1'b0;
         acc_rdata <= 24'h000000;
      end else if (ce) begin
         acc_done <= 1'b0;
         acc_refused <= 1'b0;
         if (take && refuse) begin
            acc_done <= 1'b1;
            acc_refused <= 1'b1;
            acc_rdata <= 24'h000000;
         end else if (take_int) begin
            acc_done <= 1'b1; // [RL14]
            acc_rdata <= int_rdata;
         end else if ((st_q == ST_EXT) && wc_last) begin
            acc_done <= 1'b1;
            acc_rdata <= (sp_q == SP_PM) ? ext_din : {8'h00, ext_din[23:8]};
         end
      end
   end

   // fetch port runs beside the data port and ignores overlays
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fetch_data <= 24'h000000;
      end else if (ce) begin
         fetch_data <= pm_mem[fetch_addr]; // [RL5] [RL10]
      end
   end

   always_ff @(posedge clk) begin
      if (ce && (st_q == ST_BWAIT) && wc_last &&
          (bsel_q == BOOT_BYTE_LAST)) begin
         pm_mem[{9'h000, bword_q}] <= {basm_q, ext_din[15:8]};
      end else if (take_int && acc_wr && (acc_space == SP_PM)) begin
         pm_mem[acc_addr] <= acc_wdata;
      end
      if (take_int && acc_wr && (acc_space == SP_DM) && !dec_ctrl) begin
         dm_mem[acc_addr] <= acc_wdata[15:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_len_q <= 3'h0;
      end else if (ce) begin
         ext_len_q <= ((st_q == ST_EXT) && !wc_last) ? ext_len_q + 3'h1 : 3'h0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_int_one;
      take_int |=> acc_done && !acc_refused;
   endproperty
   a_int_one: assert property (p_int_one) // [RL14]
      else $error("internal access not done in one cycle");

   property p_ext_len;
      (st_q == ST_EXT) && wc_last |-> ext_len_q == ws_q;
   endproperty
   a_ext_len: assert property (p_ext_len) // [RL14]
      else $error("external access length differs from wait setting");

   property p_dm_ws;
      take_ext && (acc_space == SP_DM) |=> ws_q == $past(data_wait_count_q);
   endproperty
   a_dm_ws: assert property (p_dm_ws) // [RL14]
      else $error("data wait setting not applied");

   property p_io_ws;
      take_ext && (acc_space == SP_IO) |=>
         ws_q == $past(io_ws) && !io_sel_n && (ext_addr[13:11] == 3'h0);
   endproperty
   a_io_ws: assert property (p_io_ws) // [RL16]
      else $error("io access wait or address wrong");

   property p_io_refuse;
      take && (acc_space == SP_IO) && !acc_io_instr |=>
         acc_refused && acc_done && io_sel_n;
   endproperty
   a_io_refuse: assert property (p_io_refuse) // [RL17]
      else $error("io space reached without io instruction");

   property p_pm_int;
      take && (acc_space == SP_PM) && !map_q &&
         (program_overlay_select_q == OVL_NONE) |=> pm_sel_n && acc_done;
   endproperty
   a_pm_int: assert property (p_pm_int) // [RL6]
      else $error("program access left chip without overlay");

   property p_pm_ovl;
      take && (acc_space == SP_PM) && !map_q && acc_addr[13] &&
         (program_overlay_select_q == OVL_ONE) |=> !pm_sel_n && !ext_addr[13];
   endproperty
   a_pm_ovl: assert property (p_pm_ovl) // [RL8]
      else $error("program overlay one address wrong");

   property p_dm_ovl;
      take && (acc_space == SP_DM) && !acc_addr[13] &&
         (data_overlay_select_q == OVL_TWO) |=> !dm_sel_n && ext_addr[13];
   endproperty
   a_dm_ovl: assert property (p_dm_ovl) // [RL13]
      else $error("data overlay two address wrong");

   property p_map_pm;
      take && (acc_space == SP_PM) && map_q && !acc_addr[13] |=>
         !pm_sel_n && !ext_addr[13];
   endproperty
   a_map_pm: assert property (p_map_pm) // [RL9]
      else $error("lower program half not external in map mode");

   property p_boot_go;
      !rst && ce && (st_q == ST_CHECK) && !bus_req &&
         !memory_map_select_pin |=>
         (st_q == ST_BOOT) && !core_run ##1 !byte_sel_n && (ext_doe == 2'h2);
   endproperty
   a_boot_go: assert property (p_boot_go) // [RL2]
      else $error("boot sequence did not start");

   c_boot_done: cover property ($rose(core_run) && !map_q);
   c_dm_wait: cover property ((st_q == ST_EXT) && wc_last && (sp_q == SP_DM)
                              && (ws_q != 3'h0));
   c_io_acc: cover property ((st_q == ST_EXT) && !io_sel_n);
   c_refused: cover property (acc_refused);
endmodule // memmap_ctrl
`default_nettype wire

// *** sim/ext_mem.sv ***
/* external memory model for the decoder's bus.
 assumes active-low strobes from memmap_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module ext_mem (
   // bus
   input wire logic clk,
   input wire logic [13:0] ext_addr,
   input wire logic sel_n,
   input wire logic rd_n,
   output logic [23:0] ext_din
);
   logic tog_q = 1'b0;
   logic [7:0] b;
   assign b = ext_addr[7:0] ^ 8'hA5;
   always_ff @(posedge clk) tog_q <= ~tog_q;
   // released bus toggles so a stale word never matches
   assign ext_din = (!sel_n && !rd_n) ? {b, b, ~b} : {24{tog_q}};
endmodule // ext_mem
`default_nettype wire

// *** sim/memmap_ctrl_bench.sv ***
/* bench for memmap_ctrl with the external memory model.
 assumes a 50 MHz clock and the zero-wait APB answer. */
`timescale 1ns/1ps
`default_nettype none
module memmap_ctrl_bench;
   typedef struct {
      logic [3:0] ov;
      logic [1:0] s;
      logic i, w, rf;
      logic [13:0] a, x;
      logic [15:0] d;
      int c;
   } row_s;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, memory_map_select_pin = 1'b0, acc_req = 1'b0;
   logic bus_req = 1'b0, stack_push = 1'b0;
   logic acc_io_instr = 1'b0, acc_wr = 1'b0, pready, pslverr, acc_done;
   logic acc_refused, core_run, pm_sel_n, dm_sel_n, io_sel_n, byte_sel_n;
   logic rd_n, wr_n;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, prd;
   logic [1:0] acc_space = 2'h0, ext_doe;
   logic [13:0] acc_addr = 14'h0, ext_addr, ea;
   logic [23:0] acc_wdata = 24'h0, acc_rdata, fetch_data, ext_dout, ext_din;
   logic [3:0] stack_level;
   logic [9:0] irq_mask;
   logic [6:0] mode_status;
   int n_fail = 0, compares = 0;
   // no strobe seen reads back as 3FFF
   row_s rows [13] = '{
      '{4'h0,2'h1,0,1,0,14'h0100,14'h3FFF,16'h1234,2},
      '{4'h0,2'h1,0,0,0,14'h0100,14'h3FFF,16'h1234,2},
      '{4'h1,2'h1,0,0,0,14'h0100,14'h0100,16'hA5A5,5},
      '{4'h2,2'h1,0,0,0,14'h0100,14'h2100,16'hA5A5,5},
      '{4'h3,2'h1,0,0,0,14'h0100,14'h3FFF,16'h1234,2},
      '{4'h4,2'h0,0,0,0,14'h2005,14'h0005,16'hA05F,3},
      '{4'h8,2'h0,0,0,0,14'h2005,14'h2005,16'hA05F,3},
      '{4'h0,2'h2,1,0,0,14'h01FF,14'h01FF,16'h5A5A,6},
      '{4'h0,2'h2,1,0,0,14'h0205,14'h0205,16'hA0A0,8},
      '{4'h0,2'h2,1,0,0,14'h0400,14'h0400,16'hA5A5,9},
      '{4'h0,2'h2,1,0,0,14'h07FF,14'h07FF,16'h5A5A,4},
      '{4'h0,2'h2,0,0,1,14'h0205,14'h3FFF,16'h0000,2},
      '{4'h0,2'h3,0,0,1,14'h0000,14'h3FFF,16'h0000,2}
   };
   memmap_ctrl DUT (
      .clk, .rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .memory_map_select_pin, .bus_req,
      .acc_req, .acc_space, .acc_io_instr, .acc_wr, .acc_addr, .acc_wdata,
      .acc_rdata, .acc_done, .acc_refused, .fetch_addr(14'h0000),
      .fetch_data, .stack_push, .stack_pop(1'b0), .stack_level,
      .core_run, .irq_mask, .mode_status, .ext_addr, .ext_dout, .ext_doe,
      .ext_din, .pm_sel_n, .dm_sel_n, .io_sel_n, .byte_sel_n, .rd_n, .wr_n
   );
   ext_mem mem (
      .clk, .ext_addr, .rd_n, .ext_din,
      .sel_n(pm_sel_n & dm_sel_n & io_sel_n & byte_sel_n)
   );
   always #10 clk = ~clk;
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic err);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      prd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task acc(input row_s r, output int n, output logic rf);
      @(posedge clk);
      acc_req <= 1'b1; acc_space <= r.s; acc_io_instr <= r.i;
      acc_wr <= r.w; acc_addr <= r.a; acc_wdata <= {8'h00, r.d};
      ea = 14'h3FFF;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (!(pm_sel_n & dm_sel_n & io_sel_n)) ea = ext_addr;
      end while (acc_done !== 1'b1);
      rf = acc_refused;
      acc_req <= 1'b0;
   endtask
   task wait_run();
      while (core_run !== 1'b1) @(posedge clk);
   endtask
   task end_of_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      logic e, rf;
      int n;
      logic [2:0] wv [4];
      row_s r;
      wv = '{3'h3, 3'h5, 3'h6, 3'h1};
      // short hold: the model clock needs no settling
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0, e);
         chk("reset reg", prd, (i < 5) ? 32'h7 : 32'h0);
      end
      apb(1'b0, 8'h28, 32'h0, e);
      chk("unmapped err", {31'h0, e}, 32'h1);
      chk("unmapped data", prd, 32'h0);
      $display("test reset values done");
      wait_run();
      chk("boot word 0", {8'h00, fetch_data}, 32'h00A5A4A7);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 8'(i * 4), {29'h0, wv[i]}, e);
         apb(1'b0, 8'(i * 4), 32'h0, e);
         chk("io wait reg", prd, {29'h0, wv[i]});
      end
      apb(1'b1, 8'h10, 32'h2, e);
      $display("test boot and waits done");
      foreach (rows[k]) begin
         apb(1'b1, 8'h14, {30'h0, rows[k].ov[3:2]}, e);
         apb(1'b1, 8'h18, {30'h0, rows[k].ov[1:0]}, e);
         acc(rows[k], n, rf);
         chk("cycles", n, rows[k].c);
         chk("ext addr", ea, rows[k].x);
         chk("refused", rf, rows[k].rf);
         if (!rows[k].w && !rows[k].rf)
            chk("rdata", acc_rdata[15:0], rows[k].d);
      end
      $display("test access table done");
      apb(1'b1, 8'h1C, 32'h55, e);
      apb(1'b1, 8'h20, 32'h3FF, e);
      stack_push <= 1'b1;
      @(posedge clk);
      stack_push <= 1'b0;
      @(posedge clk);
      chk("irq mask set", irq_mask, 32'h3FF);
      chk("mode set", mode_status, 32'h55);
      chk("stack push", stack_level, 32'h1);
      rst <= 1'b1;
      bus_req <= 1'b1;
      memory_map_select_pin <= 1'b1;
      repeat (2) @(posedge clk);
      chk("irq mask", irq_mask, 32'h0);
      chk("mode", mode_status, 32'h0);
      chk("stack", stack_level, 32'h0);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk("bus held", core_run, 32'h0);
      bus_req <= 1'b0;
      repeat (2) @(posedge clk);
      chk("map run", core_run, 32'h1);
      apb(1'b1, 8'h14, 32'h1, e);
      apb(1'b0, 8'h14, 32'h0, e);
      chk("map overlay", prd, 32'h0);
      r = rows[5];
      r.a = 14'h0005;
      acc(r, n, rf);
      chk("map low ext", ea, 14'h0005);
      r.a = 14'h2005;
      acc(r, n, rf);
      chk("map high int", ea, 14'h3FFF);
      $display("test second reset done");
      end_of_test();
   end
   initial begin
      #100000;
      n_fail++;
      end_of_test();
   end
endmodule // memmap_ctrl_bench
`default_nettype wire
